// [design/sare_pkg.sv]
// Constants for the SDRAM activate and read engine.
// Assumes a single device clock shared with the command pins.
package sare_pkg;
    localparam int DQ_W      = 16;
    localparam int BANK_W    = 2;
    localparam int ROW_W     = 12;
    localparam int COL_W     = 8;
    localparam int NUM_BANKS = 4;
    // Command code is {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_LOAD_MODE  = 4'h0;
    localparam logic [3:0] CMD_PRECHARGE  = 4'h2;
    localparam logic [3:0] CMD_ACTIVE     = 4'h3;
    localparam logic [3:0] CMD_WRITE      = 4'h4;
    localparam logic [3:0] CMD_READ       = 4'h5;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    // Mode word and address field positions.
    localparam int BL_LSB   = 0;
    localparam int TYPE_BIT = 3;
    localparam int CL_LSB   = 4;
    localparam int AP_BIT   = 10;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_3    = 3'h3;
    localparam logic [ROW_W-1:0] MODE_RESET = 12'h020;
    localparam logic [COL_W-1:0] COL_LAST   = 8'hFF;
    localparam logic [COL_W-1:0] COL_FIRST  = 8'h00;
    typedef enum logic [1:0] {
        RS_IDLE  = 2'b01,
        RS_BURST = 2'b10
    } sare_state_type;
endpackage : sare_pkg

// [design/sare_engine.sv]
// Row activation, mode capture and READ burst engine of an SDRAM device.
// Assumes the command pins are timed to i_clk_sys, and that the memory core
// returns i_core_data combinationally from the o_core_* address.
module sare_engine
    import sare_pkg::*;
(
    input  wire logic              i_clk_sys,       // Device clock
    input  wire logic              i_reset_n,       // Async reset, low
    input  wire logic              i_cs_n,          // Chip select, low
    input  wire logic              i_ras_n,         // Row strobe, low
    input  wire logic              i_cas_n,         // Column strobe, low
    input  wire logic              i_we_n,          // Write enable, low
    input  wire logic [BANK_W-1:0] i_bank,          // Bank select
    input  wire logic [ROW_W-1:0]  i_addr,          // Address bus
    input  wire logic              i_dqm,           // Byte mask, high
    input  wire logic [DQ_W-1:0]   i_core_data,     // Core read data
    output logic      [DQ_W-1:0]   o_dq,            // Read data out
    output logic                   o_dq_oe_n,       // Data drive, low
    output logic                   o_core_rd,       // Core read strobe
    output logic      [BANK_W-1:0] o_core_bank,     // Core bank
    output logic      [ROW_W-1:0]  o_core_row,      // Core row
    output logic      [COL_W-1:0]  o_core_col,      // Core column
    output logic [NUM_BANKS-1:0]   o_bank_open,     // Row open per bank
    output logic                   o_write_data_en, // Write element taken
    output logic                   o_write_invalid  // Unmasked truncation
);
    sare_state_type   state_q;
    logic [ROW_W-1:0] mode_q;
    logic [COL_W-1:0] start_q;
    logic [COL_W-1:0] k_q;
    logic             ap_q;
    logic             dqm_q;
    logic             pipe_v_q;
    logic [DQ_W-1:0]  pipe_d_q;
    logic [ROW_W-1:0] row_q [NUM_BANKS];

    function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] bl);
        case (bl)
            BL_2:    burst_mask = 8'h01;
            BL_4:    burst_mask = 8'h03;
            BL_8:    burst_mask = 8'h07;
            BL_FULL: burst_mask = 8'hFF;
            default: burst_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [COL_W-1:0] burst_col(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] k,
        input logic [COL_W-1:0] msk,
        input logic             ilv
    );
        logic [COL_W-1:0] sum;
        sum = start + k;
        burst_col = ilv ? (start ^ k) : ((start & ~msk) | (sum & msk));
    endfunction

    wire [3:0] cmd_w      = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    wire cmd_act_w        = cmd_w == CMD_ACTIVE;
    wire cmd_rd_w         = cmd_w == CMD_READ;
    wire cmd_wr_w         = cmd_w == CMD_WRITE;
    wire cmd_pre_w        = cmd_w == CMD_PRECHARGE;
    wire cmd_bst_w        = cmd_w == CMD_BURST_STOP;
    wire cmd_lmr_w        = cmd_w == CMD_LOAD_MODE;
    wire idle_cmd_w       = !(cmd_act_w | cmd_rd_w | cmd_wr_w | cmd_pre_w |
                              cmd_bst_w | cmd_lmr_w);
    wire [2:0] bl_w       = mode_q[BL_LSB +: 3];
    wire       ilv_w      = mode_q[TYPE_BIT];
    wire       cl3_w      = mode_q[CL_LSB +: 3] == CL_3;
    wire [COL_W-1:0] mask_w = burst_mask(bl_w);
    wire       full_w     = bl_w == BL_FULL;
    wire       busy_w     = state_q == RS_BURST;
    wire       last_w     = busy_w && (k_q == mask_w) && !full_w;
    wire       pre_hit_w  = cmd_pre_w &&
                            (i_addr[AP_BIT] || i_bank == o_core_bank);
    wire       stop_w     = cmd_wr_w || cmd_bst_w || pre_hit_w;
    wire [COL_W-1:0] start_col_w = i_addr[COL_W-1:0];
    wire       rd_single_w = cmd_rd_w && (mask_w == COL_FIRST) && !full_w;
    wire       ap_close_w = busy_w && ap_q && (last_w || cmd_rd_w || cmd_wr_w);
    wire       ap_now_w   = rd_single_w && i_addr[AP_BIT];
    wire [COL_W-1:0] next_col_w = burst_col(start_q, k_q, mask_w, ilv_w);
    wire             src_v_w = cl3_w ? pipe_v_q : o_core_rd;
    wire [DQ_W-1:0]  src_d_w = cl3_w ? pipe_d_q : i_core_data;
    wire             out_busy_w = o_core_rd || pipe_v_q || !o_dq_oe_n;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_q <= MODE_RESET;
        end else if (cmd_lmr_w) begin
            mode_q <= i_addr;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q     <= RS_IDLE;
            start_q     <= '0;
            k_q         <= '0;
            ap_q        <= 1'b0;
            o_core_rd   <= 1'b0;
            o_core_bank <= '0;
            o_core_row  <= '0;
            o_core_col  <= '0;
        end else if (cmd_rd_w) begin
            state_q     <= rd_single_w ? RS_IDLE : RS_BURST;
            start_q     <= start_col_w;
            k_q         <= 8'h01;
            ap_q        <= i_addr[AP_BIT];
            o_core_rd   <= 1'b1;
            o_core_bank <= i_bank;
            o_core_row  <= row_q[i_bank];
            o_core_col  <= start_col_w;
        end else if (stop_w || !busy_w) begin
            state_q   <= RS_IDLE;
            o_core_rd <= 1'b0;
        end else begin
            state_q    <= last_w ? RS_IDLE : RS_BURST;
            k_q        <= k_q + 8'h01;
            o_core_rd  <= 1'b1;
            o_core_col <= next_col_w;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pipe_v_q <= 1'b0;
            pipe_d_q <= '0;
            o_dq     <= '0;
        end else begin
            pipe_v_q <= o_core_rd && !cmd_wr_w;
            pipe_d_q <= i_core_data;
            o_dq     <= src_d_w;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dqm_q     <= 1'b1;
            o_dq_oe_n <= 1'b1;
        end else begin
            dqm_q     <= i_dqm;
            o_dq_oe_n <= cmd_wr_w || !(src_v_w && !dqm_q);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_write_invalid <= 1'b0;
            o_write_data_en <= 1'b0;
        end else begin
            o_write_invalid <= cmd_wr_w && !dqm_q && out_busy_w;
            o_write_data_en <= cmd_wr_w && !i_dqm;
        end
    end
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        wire bsel_w = i_bank == BANK_W'(b);
        wire ap_b_w = (ap_close_w && o_core_bank == BANK_W'(b)) ||
                      (ap_now_w && bsel_w);
        always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
            if (!i_reset_n) begin
                o_bank_open[b] <= 1'b0;
                row_q[b]       <= '0;
            end else if (cmd_act_w && bsel_w) begin
                o_bank_open[b] <= 1'b1;
                row_q[b]       <= i_addr;
            end else if (ap_b_w ||
                         (cmd_pre_w && (i_addr[AP_BIT] || bsel_w))) begin
                o_bank_open[b] <= 1'b0;
            end
        end
    end

    property p_cl2_first;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_rd_w && !cl3_w && !i_dqm ##1 !cmd_wr_w
        |=> !o_dq_oe_n && o_dq == $past(i_core_data);
    endproperty
    a_cl2_first: assert property (p_cl2_first)
        else $error("latency two first element not driven");

    property p_cl3_first;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_rd_w && cl3_w ##1 !cmd_wr_w && !i_dqm ##1 !cmd_wr_w
        |=> !o_dq_oe_n;
    endproperty
    a_cl3_first: assert property (p_cl3_first)
        else $error("latency three first element not driven");

    property p_mask;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_dqm |=> ##1 o_dq_oe_n;
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask did not float output two clocks on");

    property p_wr_hiz;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_wr_w |=> o_dq_oe_n && !o_core_rd;
    endproperty
    a_wr_hiz: assert property (p_wr_hiz)
        else $error("output driven after WRITE");

    property p_wr_invalid;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_wr_w && !dqm_q && !o_dq_oe_n |=> o_write_invalid;
    endproperty
    a_wr_invalid: assert property (p_wr_invalid)
        else $error("unmasked truncating WRITE not flagged");

    property p_end_hiz;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_rd_w && bl_w == BL_1 ##1 idle_cmd_w [*3] |=> o_dq_oe_n;
    endproperty
    a_end_hiz: assert property (p_end_hiz)
        else $error("output still driven after burst end");

    property p_wrap;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        busy_w && full_w && o_core_col == COL_LAST && idle_cmd_w
        |=> o_core_rd && o_core_col == COL_FIRST;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("full page burst did not wrap to column zero");

    property p_any_read;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_rd_w |=> o_core_rd && o_core_col == $past(i_addr[COL_W-1:0])
                     && o_core_bank == $past(i_bank);
    endproperty
    a_any_read: assert property (p_any_read)
        else $error("READ not started on its cycle");

    property p_stop;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_bst_w || pre_hit_w |=> !o_core_rd;
    endproperty
    a_stop: assert property (p_stop)
        else $error("burst kept issuing after terminate");

    property p_ap_close;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        last_w && ap_q && !cmd_act_w |=> !o_bank_open[$past(o_core_bank)];
    endproperty
    a_ap_close: assert property (p_ap_close)
        else $error("auto precharge left row open");

    property p_pre_close;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_pre_w |=> !o_bank_open[$past(i_bank)];
    endproperty
    a_pre_close: assert property (p_pre_close)
        else $error("PRECHARGE left row open");

    c_cl3_burst: cover property (@(posedge i_clk_sys)
        cmd_rd_w && cl3_w && bl_w == BL_4 ##3 !o_dq_oe_n);
    c_wrap: cover property (@(posedge i_clk_sys)
        busy_w && full_w && o_core_col == COL_LAST ##1 o_core_rd);
    c_wr_trunc: cover property (@(posedge i_clk_sys)
        o_core_rd && i_dqm ##2 cmd_wr_w);
endmodule : sare_engine

// [test/sare_ctrl_model.sv]
// Memory controller model that drives command, bank, address and mask.
// Assumes the bench calls its tasks from one process, one command a clock.
module sare_ctrl_model
    import sare_pkg::*;
#(
    parameter int TRCD = 3, // Activate to column delay in clocks
    parameter int TRP  = 2  // NOP clocks between precharge and next command
)
(
    input  wire logic              i_clk_sys, // Device clock
    output logic      [3:0]        o_cmd,     // {cs_n,ras_n,cas_n,we_n}
    output logic      [BANK_W-1:0] o_bank,    // Bank select
    output logic      [ROW_W-1:0]  o_addr,    // Address bus
    output logic                   o_dqm      // Byte mask, high
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] NOP_CODE = 4'h7;

    initial begin
        o_cmd  = NOP_CODE;
        o_bank = 2'h0;
        o_addr = 12'h000;
        o_dqm  = 1'b1;
    end

    task automatic issue(input logic [3:0] c, input logic [BANK_W-1:0] b,
                         input logic [ROW_W-1:0] a, input logic m);
        @(posedge i_clk_sys);
        o_cmd  <= c;
        o_bank <= b;
        o_addr <= a;
        o_dqm  <= m;
    endtask

    task automatic nop(input int n, input logic m);
        repeat (n) issue(NOP_CODE, 2'h0, 12'h000, m);
    endtask

    task automatic set_mode(input logic [ROW_W-1:0] m);
        issue(CMD_PRECHARGE, 2'h0, 12'h400, 1'b0);
        nop(TRP, 1'b0);
        issue(CMD_LOAD_MODE, 2'h0, m, 1'b0);
        nop(2, 1'b0);
    endtask

    task automatic open_row(input logic [BANK_W-1:0] b,
                            input logic [ROW_W-1:0] r);
        issue(CMD_PRECHARGE, b, 12'h000, 1'b0);
        nop(TRP, 1'b0);
        issue(CMD_ACTIVE, b, r, 1'b0);
        nop(TRCD - 1, 1'b0);
    endtask
endmodule // sare_ctrl_model

// [test/sare_engine_test.sv]
// Self-checking bench for the activate and read engine.
// Assumes a core whose word encodes its bank, row and column.
module sare_engine_test
    import sare_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [ROW_W-1:0] mode;
        logic [COL_W-1:0] col;
        int               len;
    } sare_case_type;
    sare_case_type cases [6] = '{
        '{12'h021, 8'h05, 2}, '{12'h032, 8'h01, 4}, '{12'h02A, 8'h01, 4},
        '{12'h033, 8'h0E, 8}, '{12'h03B, 8'h05, 8}, '{12'h020, 8'h03, 1}};
    logic                 clk_sys = 1'b0;
    logic                 reset_n = 1'b0;
    logic [3:0]           cmd;
    logic [BANK_W-1:0]    bank, core_bank;
    logic [ROW_W-1:0]     addr, core_row;
    logic [COL_W-1:0]     core_col;
    logic [DQ_W-1:0]      core_data, dq;
    logic [NUM_BANKS-1:0] bank_open;
    logic                 dqm, oe_n, core_rd, wr_en, wr_bad;
    int num_errors = 0, check_count = 0, cyc = 0, rd_cyc = 0;
    int n_bad = 0, n_wen = 0, nb, nw;
    logic [DQ_W-1:0]      seen [$];
    int                   stamp [$];

    always #12.5 clk_sys = ~clk_sys;
    assign core_data = {core_bank, core_row[5:0], core_col};

    sare_ctrl_model u_sare_ctrl_model (.i_clk_sys(clk_sys), .o_cmd(cmd),
        .o_bank(bank), .o_addr(addr), .o_dqm(dqm));
    sare_engine u_sare_engine (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
        .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
        .i_bank(bank), .i_addr(addr), .i_dqm(dqm), .i_core_data(core_data),
        .o_dq(dq), .o_dq_oe_n(oe_n), .o_core_rd(core_rd),
        .o_core_bank(core_bank), .o_core_row(core_row), .o_core_col(core_col),
        .o_bank_open(bank_open), .o_write_data_en(wr_en),
        .o_write_invalid(wr_bad));

    // Records each driven word with the edge that sees it.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cmd === CMD_READ) rd_cyc <= cyc;
        if (oe_n === 1'b0) begin
            seen.push_back(dq);
            stamp.push_back(cyc);
        end
        if (wr_bad === 1'b1) n_bad <= n_bad + 1;
        if (wr_en === 1'b1) n_wen <= n_wen + 1;
    end

    task automatic check(input string what, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Column of element k; a full page gives a mask of all ones.
    function automatic logic [COL_W-1:0] col_k(input logic [ROW_W-1:0] m,
            input logic [COL_W-1:0] s, input int k);
        logic [COL_W-1:0] w;
        w = (m[2:0] == BL_FULL) ? 8'hFF : (8'h01 << m[2:0]) - 8'h01;
        if (m[TYPE_BIT]) return s ^ k[COL_W-1:0];
        return (s & ~w) | ((s + k[COL_W-1:0]) & w);
    endfunction

    task automatic burst(input int i0, input logic [BANK_W-1:0] b,
            input logic [ROW_W-1:0] r, m, input logic [COL_W-1:0] s,
            input int n);
        for (int k = 0; k < n; k++) begin
            check("data", seen[i0+k], {b, r[5:0], col_k(m, s, k)});
            check("edge", stamp[i0+k] - stamp[i0], k);
        end
    endtask

    task automatic rd(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] a);
        u_sare_ctrl_model.issue(CMD_READ, b, a, 1'b0);
    endtask

    initial begin
        #(25 * 5000);
        num_errors++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        check("oe_n in reset", oe_n, 1'b1);
        check("open in reset", bank_open, 4'h0);
        reset_n <= 1'b1;
        foreach (cases[i]) begin
            u_sare_ctrl_model.set_mode(cases[i].mode);
            u_sare_ctrl_model.open_row(2'(i % 4), 12'h0A0 + 12'(i));
            seen.delete();
            stamp.delete();
            rd(2'(i % 4), {4'h0, cases[i].col});
            u_sare_ctrl_model.nop(12, 1'b0);
            check("count", seen.size(), cases[i].len);
            burst(0, 2'(i % 4), 12'h0A0 + 12'(i), cases[i].mode,
                  cases[i].col, cases[i].len);
            check("latency", stamp[0] - rd_cyc, cases[i].mode[6:4]);
            check("float", oe_n, 1'b1);
        end
        // Full page run across the page end, then stopped.
        u_sare_ctrl_model.set_mode(12'h027);
        u_sare_ctrl_model.open_row(2'h3, 12'h155);
        seen.delete();
        stamp.delete();
        rd(2'h3, 12'h0FE);
        u_sare_ctrl_model.nop(3, 1'b0);
        u_sare_ctrl_model.issue(CMD_BURST_STOP, 2'h3, 12'h000, 1'b0);
        u_sare_ctrl_model.nop(8, 1'b0);
        check("stop count", seen.size(), 4);
        burst(0, 2'h3, 12'h155, 12'h027, 8'hFE, 4);
        check("wrap", seen[2], {2'h3, 6'h15, 8'h00});
        // Second bank opened while the first stays open.
        u_sare_ctrl_model.set_mode(12'h032);
        u_sare_ctrl_model.open_row(2'h0, 12'h011);
        u_sare_ctrl_model.open_row(2'h1, 12'h022);
        seen.delete();
        stamp.delete();
        rd(2'h0, 12'h000);
        rd(2'h1, 12'h008);
        u_sare_ctrl_model.nop(10, 1'b0);
        check("seam count", seen.size(), 5);
        burst(0, 2'h0, 12'h011, 12'h032, 8'h00, 1);
        burst(1, 2'h1, 12'h022, 12'h032, 8'h08, 4);
        check("seam gap", stamp[1] - stamp[0], 1);
        // Precharge cuts a burst of eight after three words.
        u_sare_ctrl_model.set_mode(12'h023);
        u_sare_ctrl_model.open_row(2'h2, 12'h0FF);
        seen.delete();
        rd(2'h2, 12'h010);
        u_sare_ctrl_model.nop(2, 1'b0);
        check("open", bank_open[2], 1'b1);
        u_sare_ctrl_model.issue(CMD_PRECHARGE, 2'h2, 12'h000, 1'b0);
        u_sare_ctrl_model.nop(8, 1'b0);
        check("pre count", seen.size(), 3);
        check("pre closed", bank_open[2], 1'b0);
        // Auto precharge closes the row after the burst.
        u_sare_ctrl_model.open_row(2'h2, 12'h0FF);
        seen.delete();
        rd(2'h2, 12'h404);
        u_sare_ctrl_model.nop(12, 1'b0);
        check("ap count", seen.size(), 8);
        check("ap closed", bank_open[2], 1'b0);
        // Masked and unmasked WRITE cutting a read.
        for (int u = 0; u < 2; u++) begin
            u_sare_ctrl_model.open_row(2'h0, 12'h033);
            seen.delete();
            nb = n_bad;
            nw = n_wen;
            rd(2'h0, 12'h000);
            // Mask three clocks before the write, on the first pass only.
            u_sare_ctrl_model.nop(3, u == 0);
            u_sare_ctrl_model.issue(CMD_WRITE, 2'h0, 12'h000, 1'b0);
            u_sare_ctrl_model.nop(6, 1'b0);
            if (u == 0) check("masked count", seen.size(), 1);
            check("invalid", n_bad - nb, u);
            check("write taken", n_wen - nw, 1);
            check("write float", oe_n, 1'b1);
        end
        // Reset in mid burst floats the bus and restores the reset mode.
        u_sare_ctrl_model.open_row(2'h1, 12'h044);
        rd(2'h1, 12'h000);
        u_sare_ctrl_model.nop(2, 1'b0);
        reset_n <= 1'b0;
        u_sare_ctrl_model.nop(2, 1'b0);
        check("oe_n mid reset", oe_n, 1'b1);
        check("fetch mid reset", core_rd, 1'b0);
        check("open mid reset", bank_open, 4'h0);
        check("wr_en mid reset", wr_en, 1'b0);
        reset_n <= 1'b1;
        u_sare_ctrl_model.issue(CMD_ACTIVE, 2'h1, 12'h044, 1'b0);
        u_sare_ctrl_model.nop(2, 1'b0);
        seen.delete();
        stamp.delete();
        rd(2'h1, 12'h007);
        u_sare_ctrl_model.nop(8, 1'b0);
        check("reset mode count", seen.size(), 1);
        burst(0, 2'h1, 12'h044, MODE_RESET, 8'h07, 1);
        check("reset latency", stamp[0] - rd_cyc, 2);
        conclude();
    end
endmodule // sare_engine_test
